// ===== hw/rss_alu.sv
// combinational rotate and subtract unit
`timescale 1ns/1ps
module rss_alu (
	rss_alu_if.unit alu
);
	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	wire [8:0] sub_full;
	wire [4:0] sub_low;
	wire [7:0] rlc_res;
	wire [7:0] rrc_res;
	// ninth bit of k + ~w + 1 is the inverted borrow
	assign sub_full = {1'b0, alu.operand} + {1'b0, ~alu.acc} + 9'h001;
	assign sub_low = {1'b0, alu.operand[3:0]} + {1'b0, ~alu.acc[3:0]} + 5'h01;
	assign rlc_res = {alu.operand[6:0], alu.carry_in};
	assign rrc_res = {alu.carry_in, alu.operand[7:1]};

	always_comb begin
		alu.result = alu.operand;
		alu.carry_out = alu.carry_in;
		alu.half_carry_out = 1'b0;
		unique case (alu.op)
			rss_pkg::RSS_OP_RLC: begin
				alu.result = rlc_res;
				alu.carry_out = alu.operand[7];
			end
			rss_pkg::RSS_OP_RRC: begin
				alu.result = rrc_res;
				alu.carry_out = alu.operand[0];
			end
			rss_pkg::RSS_OP_SUBL: begin
				alu.result = sub_full[7:0];
				alu.carry_out = sub_full[8];
				alu.half_carry_out = sub_low[4];
			end
			rss_pkg::RSS_OP_NONE, rss_pkg::RSS_OP_HALT: begin
				alu.result = alu.operand;
			end
			// three codes of the field are unused; they pass the operand through
			default: begin
				alu.result = alu.operand;
			end
		endcase
	end
endmodule

// ===== hw/rss_exec.sv
// execution of rotate, subtract-from-literal and halt for an 8-bit core
// ----------------------------------------
// Notes on behaviour
// - rotate left: carry into bit0, bit7 out
// - rotate right: carry into bit7, bit0 out
// - target 0 writes accumulator, 1 writes file
// - literal minus accumulator into accumulator
// - carry set when accumulator at most literal
// - half carry from low nibble comparison
// - halt clears watchdog counter and prescaler
// - halt clears powerdown, sets timeout bit
// - halt stops execution until wake-up
// ----------------------------------------
`timescale 1ns/1ps
`include "rss_defs.svh"
module rss_exec (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// instruction issue, one per cycle
	input wire logic op_valid,
	input wire rss_pkg::rss_op_e op_code,
	input wire logic target_sel,
	input wire logic [7:0] file_operand,
	input wire logic [7:0] literal,
	// wake-up request from outside the core clock
	input wire logic wake_req,
	// accumulator and flags
	output logic [7:0] acc_out,
	output logic carry_flag,
	output logic half_carry_flag,
	// file register write-back
	output logic file_we,
	output logic [7:0] file_wdata,
	// power state
	output logic watchdog_clear,
	output logic powerdown_flag,
	output logic timeout_status_bit,
	output logic halted,
	output logic op_ready
);
	// ----------------------------------------
	// reset release and wake synchroniser
	// ----------------------------------------
	logic rst_meta_r, rst_sync_r;
	logic wake_meta_r, wake_sync_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	wire rst_n = rst_sync_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_meta_r <= 1'b0;
			wake_sync_r <= 1'b0;
		end else begin
			wake_meta_r <= wake_req;
			wake_sync_r <= wake_meta_r;
		end
	end

	// ----------------------------------------
	// state and operand routing
	// ----------------------------------------
	typedef enum logic {RSS_RUN, RSS_HALT} rss_state_e;
	rss_state_e state_r, state_nxt;
	logic [7:0] acc_r;
	logic carry_r, half_r;
	logic [7:0] wdog_r, presc_r;
	logic pd_r, to_r;
	logic fwe_r;
	logic [7:0] fdata_r;
	logic wclr_r;

	rss_alu_if alu_bus ();
	rss_alu u_alu (
		.alu(alu_bus.unit)
	);

	// halted core takes nothing, so the operand bus sees no operation
	wire issue = op_valid && (state_r == RSS_RUN);
	wire is_rot = issue && (op_code == rss_pkg::RSS_OP_RLC || op_code == rss_pkg::RSS_OP_RRC);
	wire is_sub = issue && (op_code == rss_pkg::RSS_OP_SUBL);
	wire is_halt = issue && (op_code == rss_pkg::RSS_OP_HALT);
	wire rot_to_file = is_rot && (target_sel == `RSS_DEST_FILE);
	wire rot_to_acc = is_rot && (target_sel == `RSS_DEST_ACC);

	assign alu_bus.op = issue ? op_code : rss_pkg::RSS_OP_NONE;
	assign alu_bus.operand = is_sub ? literal : file_operand;
	assign alu_bus.acc = acc_r;
	assign alu_bus.carry_in = carry_r;

	always_comb begin
		state_nxt = state_r;
		if (is_halt) begin
			state_nxt = RSS_HALT;
		end else if (state_r == RSS_HALT && wake_sync_r) begin
			state_nxt = RSS_RUN;
		end
	end

	// ----------------------------------------
	// registers, every operation retires in one cycle
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RSS_RUN;
			acc_r <= `RSS_ACC_RST;
			carry_r <= 1'b0;
			half_r <= 1'b0;
			fwe_r <= 1'b0;
			fdata_r <= 8'h00;
			wclr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fwe_r <= rot_to_file;
			fdata_r <= rot_to_file ? alu_bus.result : fdata_r;
			wclr_r <= is_halt;
			if (rot_to_acc || is_sub) begin
				acc_r <= alu_bus.result;
			end
			if (is_rot || is_sub) begin
				carry_r <= alu_bus.carry_out;
			end
			if (is_sub) begin
				half_r <= alu_bus.half_carry_out;
			end
		end
	end

	// power status: reset powers up with both bits high
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_r <= 1'b1;
			to_r <= 1'b1;
			wdog_r <= `RSS_WDOG_CLR;
			presc_r <= `RSS_PRESC_CLR;
		end else if (is_halt) begin
			pd_r <= 1'b0;
			to_r <= 1'b1;
			wdog_r <= `RSS_WDOG_CLR;
			presc_r <= `RSS_PRESC_CLR;
		end else if (state_r == RSS_RUN) begin
			// the count advances only while running; the oscillator is off in halt
			{wdog_r, presc_r} <= {wdog_r, presc_r} + 16'h0001;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign acc_out = acc_r;
	assign carry_flag = carry_r;
	assign half_carry_flag = half_r;
	assign file_we = fwe_r;
	assign file_wdata = fdata_r;
	assign watchdog_clear = wclr_r;
	assign powerdown_flag = pd_r;
	assign timeout_status_bit = to_r;
	assign halted = (state_r == RSS_HALT);
	assign op_ready = (state_r == RSS_RUN);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_sub_issue;
		is_sub;
	endsequence
	sequence s_halt_issue;
		is_halt;
	endsequence

	a_rotl_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rot_to_acc && op_code == rss_pkg::RSS_OP_RLC |=>
		acc_r == {$past(file_operand[6:0]), $past(carry_r)} && carry_r == $past(file_operand[7]))
		else $error("rotate left result wrong");
	a_rotr_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rot_to_file && op_code == rss_pkg::RSS_OP_RRC |=>
		fdata_r == {$past(carry_r), $past(file_operand[7:1])} && carry_r == $past(file_operand[0]))
		else $error("rotate right result wrong");
	a_rot_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rot_to_file |=> fwe_r && $stable(acc_r))
		else $error("file target touched accumulator");
	a_sub_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_sub_issue |=> acc_r == 8'($past(literal) - $past(acc_r)))
		else $error("subtract result wrong");
	a_sub_carry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_sub_issue |=> carry_r == ($past(acc_r) <= $past(literal)))
		else $error("subtract carry wrong");
	a_sub_half: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_sub_issue |=> half_r == ($past(acc_r[3:0]) <= $past(literal[3:0])))
		else $error("half carry wrong");
	a_halt_wdog: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_halt_issue |=> wdog_r == `RSS_WDOG_CLR && presc_r == `RSS_PRESC_CLR && wclr_r)
		else $error("watchdog not cleared");
	a_halt_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_halt_issue |=> !pd_r && to_r)
		else $error("halt status bits wrong");
	a_halt_stall: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_halt_issue |=> halted && !op_ready ##1 (halted || $past(wake_sync_r)))
		else $error("halt did not stop execution");
	a_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		issue && op_code != rss_pkg::RSS_OP_HALT |=> op_ready && !halted)
		else $error("operation did not retire in one cycle");
endmodule

// ===== include/rss_alu_if.sv
// operand and result bundle between the execution top and its arithmetic unit
`timescale 1ns/1ps
interface rss_alu_if;
	rss_pkg::rss_op_e op;
	logic [7:0] operand;
	logic [7:0] acc;
	logic carry_in;
	logic [7:0] result;
	logic carry_out;
	logic half_carry_out;
	modport core (output op, output operand, output acc, output carry_in,
		input result, input carry_out, input half_carry_out);
	modport unit (input op, input operand, input acc, input carry_in,
		output result, output carry_out, output half_carry_out);
endinterface

// ===== include/rss_defs.svh
// constants for the rotate/subtract/halt execution block
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
`define RSS_ACC_RST 8'h00
`define RSS_WDOG_CLR 8'h00
`define RSS_PRESC_CLR 8'h00
`define RSS_DEST_ACC 1'b0
`define RSS_DEST_FILE 1'b1
`define RSS_OP_CYCLES 1
`endif

// ===== include/rss_pkg.sv
// types for the rotate/subtract/halt execution block
package rss_pkg;
	typedef enum logic [2:0] {
		RSS_OP_NONE,
		RSS_OP_RLC,
		RSS_OP_RRC,
		RSS_OP_SUBL,
		RSS_OP_HALT
	} rss_op_e;
endpackage

// ===== tb/tb_rotate_sub_sleep_exec.sv
// self-checking bench for the rotate/subtract/halt execution block
`timescale 1ns/1ps
module tb_rotate_sub_sleep_exec;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic op_valid = 1'b0;
	logic target_sel = 1'b0;
	logic wake_req = 1'b0;
	rss_pkg::rss_op_e op_code = rss_pkg::RSS_OP_NONE;
	logic [7:0] file_operand = 8'h00;
	logic [7:0] literal = 8'h00;
	logic [7:0] acc_out, file_wdata;
	logic carry_flag, half_carry_flag, file_we, watchdog_clear;
	logic powerdown_flag, timeout_status_bit, halted, op_ready;
	// reference copy of the architectural state
	logic [7:0] m_acc = 8'h00;
	logic m_c = 1'b0;
	logic m_dc = 1'b0;
	int num_errors = 0;
	int cmp_count = 0;

	rss_exec dut_u (.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
		.target_sel(target_sel), .file_operand(file_operand), .literal(literal), .wake_req(wake_req),
		.acc_out(acc_out), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
		.file_we(file_we), .file_wdata(file_wdata), .watchdog_clear(watchdog_clear),
		.powerdown_flag(powerdown_flag), .timeout_status_bit(timeout_status_bit),
		.halted(halted), .op_ready(op_ready));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// inputs always move 1 ns after the rising edge
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask

	// leaves op_valid high so that calls run back to back
	task automatic do_op(input rss_pkg::rss_op_e op, input logic sel, input logic [7:0] f, input logic [7:0] k);
		logic [7:0] res;
		logic we;
		op_valid = 1'b1;
		op_code = op;
		target_sel = sel;
		file_operand = f;
		literal = k;
		res = m_acc;
		case (op)
		rss_pkg::RSS_OP_RLC: begin
			res = {f[6:0], m_c};
			m_c = f[7];
		end
		rss_pkg::RSS_OP_RRC: begin
			res = {m_c, f[7:1]};
			m_c = f[0];
		end
		rss_pkg::RSS_OP_SUBL: begin
			m_c = (m_acc <= k);
			m_dc = (m_acc[3:0] <= k[3:0]);
			res = k - m_acc;
		end
		default: ;
		endcase
		we = (op == rss_pkg::RSS_OP_RLC || op == rss_pkg::RSS_OP_RRC) && sel;
		if (!we)
			m_acc = res;
		step();
		chk(acc_out, m_acc, "accumulator");
		chk(carry_flag, m_c, "carry");
		chk(half_carry_flag, m_dc, "half carry");
		chk(file_we, we, "file write");
		if (we)
			chk(file_wdata, res, "file data");
		chk(halted, op == rss_pkg::RSS_OP_HALT, "halted");
		chk(watchdog_clear, op == rss_pkg::RSS_OP_HALT, "watchdog clear");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		step();
		step();
		chk(acc_out, 8'h00, "reset accumulator");
		chk(powerdown_flag, 1'b1, "reset powerdown");
		chk(op_ready, 1'b1, "reset ready");
		$display("test reset done");
	endtask

	task automatic t_rotate;
		logic [7:0] pat [4] = '{8'h81, 8'h7e, 8'h01, 8'h80};
		do_op(rss_pkg::RSS_OP_RLC, 1'b0, 8'he6, 8'h00);
		do_op(rss_pkg::RSS_OP_NONE, 1'b1, 8'hff, 8'hff);
		for (int i = 0; i < 4; i++) begin
			for (int s = 0; s < 2; s++) begin
				do_op(rss_pkg::RSS_OP_RLC, s[0], pat[i], 8'h00);
				do_op(rss_pkg::RSS_OP_RRC, s[0], pat[i], 8'h00);
			end
		end
		op_valid = 1'b0;
		step();
		chk(file_we, 1'b0, "write pulse");
		$display("test rotate done");
	endtask

	task automatic t_sub;
		logic [7:0] ks [6] = '{8'h00, 8'hff, 8'h10, 8'h0f, 8'h80, 8'h7f};
		for (int i = 0; i < 6; i++) begin
			do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, m_acc);
			do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, ks[i]);
			do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, m_acc - 8'h01);
		end
		// accumulator 0f against literal 10: carry set while half carry is clear
		do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, m_acc + 8'h0f);
		do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, 8'h10);
		$display("test subtract done");
	endtask

	task automatic t_halt;
		int n;
		do_op(rss_pkg::RSS_OP_HALT, 1'b0, 8'h00, 8'h00);
		chk(powerdown_flag, 1'b0, "powerdown");
		chk(timeout_status_bit, 1'b1, "timeout");
		op_code = rss_pkg::RSS_OP_RLC;
		target_sel = 1'b1;
		file_operand = 8'hff;
		step();
		step();
		chk(file_we, 1'b0, "write while halted");
		chk(acc_out, m_acc, "acc while halted");
		chk(watchdog_clear, 1'b0, "clear pulse");
		op_valid = 1'b0;
		wake_req = 1'b1;
		n = 0;
		while (halted !== 1'b0) begin
			step();
			n++;
			if (n > 8) begin
				num_errors++;
				$display("wrong value at %0t: no wake", $time);
				return;
			end
		end
		wake_req = 1'b0;
		do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, 8'h42);
		$display("test halt done");
	endtask

	// reset in mid-run must bring the powerdown bit back high
	task automatic t_rerun;
		op_valid = 1'b0;
		rstn = 1'b0;
		step();
		chk(acc_out, 8'h00, "mid reset accumulator");
		chk(carry_flag, 1'b0, "mid reset carry");
		chk(powerdown_flag, 1'b1, "mid reset powerdown");
		rstn = 1'b1;
		m_acc = 8'h00;
		m_c = 1'b0;
		m_dc = 1'b0;
		step();
		step();
		do_op(rss_pkg::RSS_OP_SUBL, 1'b0, 8'h00, 8'h05);
		$display("test mid-run reset done");
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		t_reset();
		t_rotate();
		t_sub();
		t_halt();
		t_rerun();
		complete_run();
	end
endmodule
